//--- design/ppo_pin_cell.sv
`timescale 1ns/10ps
module ppo_pin_cell (
  input wire logic dir_bit_i,
  input wire logic out_reg_bit_i,
  input wire logic global_pullup_disable_i,
  input wire logic sleep_i,
  input wire logic irq_clamp_override_i,
  input wire logic pullup_override_en_i,
  input wire logic pullup_override_val_i,
  input wire logic dir_override_en_i,
  input wire logic dir_override_val_i,
  input wire logic out_value_override_en_i,
  input wire logic out_value_override_val_i,
  input wire logic input_en_override_en_i,
  input wire logic input_en_override_val_i,
  input wire logic pad_i,
  output logic pullup_en_o,
  output logic drive_en_o,
  output logic drive_val_o,
  output logic input_en_o,
  output logic alt_digital_in_o
);

  // ----------------------------------------
  // pull-up
  // ----------------------------------------
  // (R4) override or 0b010
  assign pullup_en_o = pullup_override_en_i ? pullup_override_val_i :
                       (!dir_bit_i && out_reg_bit_i && !global_pullup_disable_i);

  // ----------------------------------------
  // driver
  // ----------------------------------------
  // (R5) direction override select
  // (R16) plain direction bit
  assign drive_en_o = dir_override_en_i ? dir_override_val_i : dir_bit_i;
  // (R6) value override select
  assign drive_val_o = out_value_override_en_i ? out_value_override_val_i : out_reg_bit_i;

  // ----------------------------------------
  // input enable and clamp
  // ----------------------------------------
  // (R8) override beats sleep
  // (R2) enabled interrupt lifts clamp
  assign input_en_o = input_en_override_en_i ? input_en_override_val_i :
                      (!sleep_i || irq_clamp_override_i);
  // (R1) clamp low before trigger
  // (R9) unsynchronised tap
  assign alt_digital_in_o = pad_i & input_en_o;

endmodule

//--- design/ppo_pkg.sv
package ppo_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PPO_PINS = 8;
  localparam int PPO_AW = 8;
  localparam int PPO_DW = 32;

  typedef logic [PPO_PINS-1:0] ppo_pins_t;
  typedef logic [PPO_AW-1:0] ppo_addr_t;
  typedef logic [PPO_DW-1:0] ppo_data_t;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam ppo_addr_t PPO_OUT_ADDR = 8'h00;
  localparam ppo_addr_t PPO_DIR_ADDR = 8'h04;
  localparam ppo_addr_t PPO_PIN_ADDR = 8'h08;
  localparam ppo_addr_t PPO_CTRL_ADDR = 8'h0C;
  localparam ppo_addr_t PPO_RISE_ADDR = 8'h10;
  localparam ppo_addr_t PPO_FALL_ADDR = 8'h14;
  localparam ppo_addr_t PPO_STAT_ADDR = 8'h18;
  localparam ppo_addr_t PPO_CLR_ADDR = 8'h1C;
  localparam ppo_addr_t PPO_IEN_ADDR = 8'h20;

  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int PPO_CTRL_PUD_BIT = 0;
  localparam int PPO_CTRL_PCIE_BIT = 1;
  localparam int PPO_CTRL_W = 2;
  localparam ppo_pins_t PPO_PINS_RST = 8'h00;
  localparam logic [PPO_CTRL_W-1:0] PPO_CTRL_RST = 2'h0;
  localparam ppo_data_t PPO_DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // pin assignments of the alternate functions
  // ----------------------------------------
  localparam int PPO_BIT_OSC_OUT = 7;
  localparam int PPO_BIT_OSC_IN = 6;
  localparam int PPO_BIT_SCK = 5;
  localparam int PPO_BIT_MISO = 4;
  localparam int PPO_BIT_MOSI = 3;
  localparam int PPO_BIT_SS = 2;
  localparam int PPO_BIT_CAPTURE = 0;

endpackage

//--- design/ppo_port.sv
`timescale 1ns/10ps
// Operation
// (R1) sleep clamps digital inputs to ground
// (R2) enabled pin interrupt lifts the clamp
// (R3) waking with high pin sets flag
// (R4) pull-up from override or 0b010
// (R5) driver enable from override or direction
// (R6) driven value from override or output
// (R7) toggle override inverts output register bit
// (R8) input enable override beats sleep state
// (R9) alternate input taken before port synchroniser
// (R10) overrides come from owning peripheral modules
// (R11) strobes per port, sleep/pud global
// (R12) pull-up off while reset active
// (R13) pin change sources, oscillator pins 6/7
// (R14) spi pins on bits 5..2
// (R15) timer compare/capture and clock out
// (R16) direction bit selects output or input
// (R17) pin register write toggles output bit
module ppo_port (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire ppo_pkg::ppo_addr_t PADDR_I,
  input wire ppo_pkg::ppo_data_t PWDATA_I,
  output logic PREADY_O,
  output ppo_pkg::ppo_data_t PRDATA_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  input wire logic SLEEP_I,
  input wire ppo_pkg::ppo_pins_t PULLUP_OVERRIDE_EN_I,
  input wire ppo_pkg::ppo_pins_t PULLUP_OVERRIDE_VAL_I,
  input wire ppo_pkg::ppo_pins_t DIR_OVERRIDE_EN_I,
  input wire ppo_pkg::ppo_pins_t DIR_OVERRIDE_VAL_I,
  input wire ppo_pkg::ppo_pins_t OUT_VALUE_OVERRIDE_EN_I,
  input wire ppo_pkg::ppo_pins_t OUT_VALUE_OVERRIDE_VAL_I,
  input wire ppo_pkg::ppo_pins_t TOGGLE_OVERRIDE_EN_I,
  input wire ppo_pkg::ppo_pins_t INPUT_EN_OVERRIDE_EN_I,
  input wire ppo_pkg::ppo_pins_t INPUT_EN_OVERRIDE_VAL_I,
  input wire ppo_pkg::ppo_pins_t PAD_I,
  output ppo_pkg::ppo_pins_t PAD_O,
  output ppo_pkg::ppo_pins_t PAD_OE_N_O,
  output ppo_pkg::ppo_pins_t PULLUP_EN_O,
  output ppo_pkg::ppo_pins_t OUT_REG_BIT_O,
  output ppo_pkg::ppo_pins_t DIR_BIT_O,
  output logic GLOBAL_PULLUP_DISABLE_O,
  output ppo_pkg::ppo_pins_t ALT_DIGITAL_IN_O,
  output ppo_pkg::ppo_pins_t PIN_CHANGE_SRC_O,
  output logic MAIN_OSC_IN_O,
  output logic TIMER_OSC_IN_O,
  output logic SPI_SCK_IN_O,
  output logic SPI_MISO_IN_O,
  output logic SPI_MOSI_IN_O,
  output logic SPI_SS_IN_O,
  output logic TIMER1_CAPTURE_IN_O
);
  import ppo_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic run;
    ppo_pins_t out_reg;
    ppo_pins_t dir_reg;
    logic [PPO_CTRL_W-1:0] ctrl;
    ppo_pins_t rise_sense;
    ppo_pins_t fall_sense;
    ppo_pins_t irq_status;
    ppo_pins_t irq_enable;
    ppo_pins_t pin_prev;
    ppo_data_t rdata;
    logic err;
  } ppo_state_s;

  ppo_state_s st_reg;
  ppo_state_s st_next;

  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  ppo_pins_t cell_pullup;
  ppo_pins_t cell_drive_en;
  ppo_pins_t cell_drive_val;
  ppo_pins_t cell_input_en;
  ppo_pins_t cell_alt_in;
  ppo_pins_t clamp_lift;
  ppo_pins_t pin_sync;
  logic global_pullup_disable;
  logic pcie;

  assign global_pullup_disable = st_reg.ctrl[PPO_CTRL_PUD_BIT];
  assign pcie = st_reg.ctrl[PPO_CTRL_PCIE_BIT];

  // (R2) mask bit with group enable
  assign clamp_lift = st_reg.irq_enable & {PPO_PINS{pcie}};

  // (R11) sleep and pud fan to every pin
  for (genvar n = 0; n < PPO_PINS; n++) begin : g_pin
    ppo_pin_cell u_cell (
      .dir_bit_i(st_reg.dir_reg[n]),
      .out_reg_bit_i(st_reg.out_reg[n]),
      .global_pullup_disable_i(global_pullup_disable),
      .sleep_i(SLEEP_I),
      .irq_clamp_override_i(clamp_lift[n]),
      .pullup_override_en_i(PULLUP_OVERRIDE_EN_I[n]),
      .pullup_override_val_i(PULLUP_OVERRIDE_VAL_I[n]),
      .dir_override_en_i(DIR_OVERRIDE_EN_I[n]),
      .dir_override_val_i(DIR_OVERRIDE_VAL_I[n]),
      .out_value_override_en_i(OUT_VALUE_OVERRIDE_EN_I[n]),
      .out_value_override_val_i(OUT_VALUE_OVERRIDE_VAL_I[n]),
      .input_en_override_en_i(INPUT_EN_OVERRIDE_EN_I[n]),
      .input_en_override_val_i(INPUT_EN_OVERRIDE_VAL_I[n]),
      .pad_i(PAD_I[n]),
      .pullup_en_o(cell_pullup[n]),
      .drive_en_o(cell_drive_en[n]),
      .drive_val_o(cell_drive_val[n]),
      .input_en_o(cell_input_en[n]),
      .alt_digital_in_o(cell_alt_in[n])
    );
  end

  // ----------------------------------------
  // port synchroniser
  // ----------------------------------------
  // clamped value, so a pin clamped in sleep shows as low here
  ppo_sync2 u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(cell_alt_in),
    .q_o(pin_sync)
  );

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup_rd;
  logic wr_en;
  logic addr_hit;

  assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;

  always_comb begin
    unique case (PADDR_I)
      PPO_OUT_ADDR,
      PPO_DIR_ADDR,
      PPO_PIN_ADDR,
      PPO_CTRL_ADDR,
      PPO_RISE_ADDR,
      PPO_FALL_ADDR,
      PPO_STAT_ADDR,
      PPO_CLR_ADDR,
      PPO_IEN_ADDR: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  ppo_data_t rd_word;

  always_comb begin
    rd_word = PPO_DATA_ZERO;
    unique case (PADDR_I)
      PPO_OUT_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.out_reg;
      end
      PPO_DIR_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.dir_reg;
      end
      PPO_PIN_ADDR: begin
        rd_word[PPO_PINS-1:0] = pin_sync;
      end
      PPO_CTRL_ADDR: begin
        rd_word[PPO_CTRL_W-1:0] = st_reg.ctrl;
      end
      PPO_RISE_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.rise_sense;
      end
      PPO_FALL_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.fall_sense;
      end
      PPO_STAT_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.irq_status;
      end
      PPO_IEN_ADDR: begin
        rd_word[PPO_PINS-1:0] = st_reg.irq_enable;
      end
      default: begin
        rd_word = PPO_DATA_ZERO;
      end
    endcase
  end

  // ----------------------------------------
  // pin change events
  // ----------------------------------------
  ppo_pins_t ev_rise;
  ppo_pins_t ev_fall;
  ppo_pins_t events;

  // (R3) clamp release reads as a rise
  assign ev_rise = pin_sync & ~st_reg.pin_prev & st_reg.rise_sense;
  assign ev_fall = ~pin_sync & st_reg.pin_prev & st_reg.fall_sense;
  // (R13) every bit is a change source
  assign events = ev_rise | ev_fall;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  ppo_pins_t wr_pins;
  ppo_pins_t clr_mask;
  ppo_pins_t pin_toggle;

  assign wr_pins = PWDATA_I[PPO_PINS-1:0];

  always_comb begin
    st_next = st_reg;
    st_next.run = 1'b1;
    st_next.pin_prev = pin_sync;
    clr_mask = PPO_PINS_RST;
    pin_toggle = PPO_PINS_RST;
    if (wr_en && PADDR_I == PPO_PIN_ADDR) begin
      // (R17) write one toggles output bit
      pin_toggle = wr_pins;
    end
    if (wr_en && PADDR_I == PPO_CLR_ADDR) begin
      clr_mask = wr_pins;
    end
    if (wr_en && PADDR_I == PPO_OUT_ADDR) begin
      st_next.out_reg = wr_pins;
    end
    // (R7) toggle override inverts bit
    st_next.out_reg = st_next.out_reg ^ pin_toggle ^ TOGGLE_OVERRIDE_EN_I;
    if (wr_en && PADDR_I == PPO_DIR_ADDR) begin
      st_next.dir_reg = wr_pins;
    end
    if (wr_en && PADDR_I == PPO_CTRL_ADDR) begin
      st_next.ctrl = PWDATA_I[PPO_CTRL_W-1:0];
    end
    if (wr_en && PADDR_I == PPO_RISE_ADDR) begin
      st_next.rise_sense = wr_pins;
    end
    if (wr_en && PADDR_I == PPO_FALL_ADDR) begin
      st_next.fall_sense = wr_pins;
    end
    if (wr_en && PADDR_I == PPO_IEN_ADDR) begin
      st_next.irq_enable = wr_pins;
    end
    // set wins over a same-cycle clear
    st_next.irq_status = (st_reg.irq_status & ~clr_mask) | events;
    if (setup_rd) begin
      st_next.rdata = addr_hit ? rd_word : PPO_DATA_ZERO;
    end
    if (PSEL_I && !PENABLE_I) begin
      st_next.err = !addr_hit;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg.run <= 1'b0;
      st_reg.out_reg <= PPO_PINS_RST;
      st_reg.dir_reg <= PPO_PINS_RST;
      st_reg.ctrl <= PPO_CTRL_RST;
      st_reg.rise_sense <= PPO_PINS_RST;
      st_reg.fall_sense <= PPO_PINS_RST;
      st_reg.irq_status <= PPO_PINS_RST;
      st_reg.irq_enable <= PPO_PINS_RST;
      st_reg.pin_prev <= PPO_PINS_RST;
      st_reg.rdata <= PPO_DATA_ZERO;
      st_reg.err <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // zero wait states keeps the pin toggle exact to the cycle
  assign PREADY_O = 1'b1;
  assign PRDATA_O = st_reg.rdata;
  assign PSLVERR_O = PSEL_I && PENABLE_I && st_reg.err;
  assign IRQ_O = |(st_reg.irq_status & st_reg.irq_enable);

  // ----------------------------------------
  // pads
  // ----------------------------------------
  // run is cleared asynchronously, so overrides cannot drive during reset
  // (R12) pull-up held off in reset
  assign PULLUP_EN_O = cell_pullup & ~cell_drive_en & {PPO_PINS{st_reg.run}};
  // (R16) output only when enabled
  assign PAD_OE_N_O = ~(cell_drive_en & {PPO_PINS{st_reg.run}});
  assign PAD_O = cell_drive_val & {PPO_PINS{st_reg.run}};

  // ----------------------------------------
  // peripheral side
  // ----------------------------------------
  // (R10) owners build overrides from these
  assign OUT_REG_BIT_O = st_reg.out_reg;
  assign DIR_BIT_O = st_reg.dir_reg;
  assign GLOBAL_PULLUP_DISABLE_O = global_pullup_disable;

  // (R9) unsynchronised alternate inputs
  assign ALT_DIGITAL_IN_O = cell_alt_in;
  // (R13) change sources and oscillators
  assign PIN_CHANGE_SRC_O = cell_alt_in;
  assign MAIN_OSC_IN_O = cell_alt_in[PPO_BIT_OSC_IN];
  assign TIMER_OSC_IN_O = cell_alt_in[PPO_BIT_OSC_IN];
  // (R14) spi inputs on bits 5..2
  assign SPI_SCK_IN_O = cell_alt_in[PPO_BIT_SCK];
  assign SPI_MISO_IN_O = cell_alt_in[PPO_BIT_MISO];
  assign SPI_MOSI_IN_O = cell_alt_in[PPO_BIT_MOSI];
  assign SPI_SS_IN_O = cell_alt_in[PPO_BIT_SS];
  // (R15) capture input on bit 0
  assign TIMER1_CAPTURE_IN_O = cell_alt_in[PPO_BIT_CAPTURE];

endmodule

//--- design/ppo_sync2.sv
`timescale 1ns/10ps
module ppo_sync2 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ppo_pkg::ppo_pins_t d_i,
  output ppo_pkg::ppo_pins_t q_o
);
  import ppo_pkg::*;

  typedef struct packed {
    ppo_pins_t meta;
    ppo_pins_t stable;
  } ppo_sync_s;

  ppo_sync_s st_reg;
  ppo_sync_s st_next;

  // ----------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------
  always_comb begin
    st_next.meta = d_i;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.stable;

endmodule

//--- sim/ppo_pad_model.sv
`timescale 1ns/10ps
// ----
// pad and far-side driver
// ----
module ppo_pad_model
  import ppo_pkg::*;
(
  input wire logic clk_i,
  input wire ppo_pins_t pad_o_i,
  input wire ppo_pins_t oe_n_i,
  input wire ppo_pins_t pullup_i,
  input wire ppo_pins_t ext_en_i,
  input wire ppo_pins_t ext_val_i,
  output ppo_pins_t pad_i_o
);
  // floating pin never holds its old level
  ppo_pins_t float_q = 8'h5A;
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign pad_i_o = (~oe_n_i & pad_o_i) | (oe_n_i & ext_en_i & ext_val_i)
    | (oe_n_i & ~ext_en_i & (pullup_i | float_q));
endmodule

//--- sim/ppo_port_chk.sv
`timescale 1ns/10ps
// ----
// port checker
// ----
module ppo_port_chk
  import ppo_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire ppo_addr_t PADDR_I,
  input wire ppo_data_t PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IRQ_O,
  input wire logic SLEEP_I,
  input wire ppo_pins_t PULLUP_OVERRIDE_EN_I,
  input wire ppo_pins_t PULLUP_OVERRIDE_VAL_I,
  input wire ppo_pins_t DIR_OVERRIDE_EN_I,
  input wire ppo_pins_t DIR_OVERRIDE_VAL_I,
  input wire ppo_pins_t OUT_VALUE_OVERRIDE_EN_I,
  input wire ppo_pins_t OUT_VALUE_OVERRIDE_VAL_I,
  input wire ppo_pins_t TOGGLE_OVERRIDE_EN_I,
  input wire ppo_pins_t INPUT_EN_OVERRIDE_EN_I,
  input wire ppo_pins_t INPUT_EN_OVERRIDE_VAL_I,
  input wire ppo_pins_t PAD_I,
  input wire ppo_pins_t PAD_O,
  input wire ppo_pins_t PAD_OE_N_O,
  input wire ppo_pins_t PULLUP_EN_O,
  input wire ppo_pins_t OUT_REG_BIT_O,
  input wire ppo_pins_t DIR_BIT_O,
  input wire logic GLOBAL_PULLUP_DISABLE_O,
  input wire ppo_pins_t ALT_DIGITAL_IN_O,
  input wire ppo_pins_t PIN_CHANGE_SRC_O,
  input wire logic SPI_SCK_IN_O,
  input wire logic TIMER1_CAPTURE_IN_O
);
  logic wr;
  ppo_pins_t wd, oe_x, pv_x, pu_x, in_x;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign wd = PWDATA_I[7:0];
  assign oe_x = (DIR_OVERRIDE_EN_I & DIR_OVERRIDE_VAL_I) | (~DIR_OVERRIDE_EN_I & DIR_BIT_O);
  assign pv_x = (OUT_VALUE_OVERRIDE_EN_I & OUT_VALUE_OVERRIDE_VAL_I)
    | (~OUT_VALUE_OVERRIDE_EN_I & OUT_REG_BIT_O);
  // pull-up held off while driving, a choice of the design
  assign pu_x = ((PULLUP_OVERRIDE_EN_I & PULLUP_OVERRIDE_VAL_I) | (~PULLUP_OVERRIDE_EN_I
    & ~DIR_BIT_O & OUT_REG_BIT_O & ~{8{GLOBAL_PULLUP_DISABLE_O}})) & ~oe_x;
  assign in_x = PAD_I & (INPUT_EN_OVERRIDE_VAL_I | ~INPUT_EN_OVERRIDE_EN_I);

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_oe; PAD_OE_N_O == ~oe_x; endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_val; ((PAD_O ^ pv_x) & ~PAD_OE_N_O) == 8'h00; endproperty
  a_val: assert property (p_val) else $error("driven value wrong");
  property p_pu; PULLUP_EN_O == pu_x; endproperty
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  property p_tog;
    $past(RST_N_I) && !$past(wr) |->
      OUT_REG_BIT_O == ($past(OUT_REG_BIT_O) ^ $past(TOGGLE_OVERRIDE_EN_I));
  endproperty
  a_tog: assert property (p_tog) else $error("toggle override wrong");
  property p_pinw;
    $past(wr) && $past(PADDR_I) == PPO_PIN_ADDR |->
      OUT_REG_BIT_O == ($past(OUT_REG_BIT_O) ^ $past(wd) ^ $past(TOGGLE_OVERRIDE_EN_I));
  endproperty
  a_pinw: assert property (p_pinw) else $error("pin write toggle wrong");
  property p_din; ((ALT_DIGITAL_IN_O ^ in_x) & (INPUT_EN_OVERRIDE_EN_I | ~{8{SLEEP_I}})) == 8'h00;
  endproperty
  a_din: assert property (p_din) else $error("digital input wrong");
  property p_map;
    {PIN_CHANGE_SRC_O, SPI_SCK_IN_O, TIMER1_CAPTURE_IN_O}
      == {ALT_DIGITAL_IN_O, ALT_DIGITAL_IN_O[5], ALT_DIGITAL_IN_O[0]};
  endproperty
  a_map: assert property (p_map) else $error("alternate input map wrong");
  property p_rdy; PSEL_I && PENABLE_I |-> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_err; PSEL_I && PENABLE_I && PADDR_I > PPO_IEN_ADDR |-> PSLVERR_O; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_irq; wr && PADDR_I == PPO_IEN_ADDR && wd == 8'h00 |=> !IRQ_O; endproperty
  a_irq: assert property (p_irq) else $error("masked interrupt high");

  c_sleep: cover property (SLEEP_I && PAD_I != 8'h00);
  c_pinw: cover property (wr && PADDR_I == PPO_PIN_ADDR);
  c_irq: cover property ($rose(IRQ_O));
endmodule

bind ppo_port ppo_port_chk chk_u (.*);

//--- sim/tb.sv
`timescale 1ns/10ps
// ----
// port bench
// ----
module tb;
  import ppo_pkg::*;
  logic CLK_I = 0, RST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, SLEEP_I = 0;
  ppo_addr_t PADDR_I = 8'h00;
  ppo_data_t PWDATA_I = 32'h0000_0000, PRDATA_O, q;
  logic PREADY_O, PSLVERR_O, IRQ_O, GLOBAL_PULLUP_DISABLE_O, e;
  logic MAIN_OSC_IN_O, TIMER_OSC_IN_O, SPI_SCK_IN_O, SPI_MISO_IN_O;
  logic SPI_MOSI_IN_O, SPI_SS_IN_O, TIMER1_CAPTURE_IN_O;
  ppo_pins_t PULLUP_OVERRIDE_EN_I = 8'hFF, PULLUP_OVERRIDE_VAL_I = 8'hFF;
  ppo_pins_t DIR_OVERRIDE_EN_I = 8'h00, DIR_OVERRIDE_VAL_I = 8'h00;
  ppo_pins_t OUT_VALUE_OVERRIDE_EN_I = 8'h00, OUT_VALUE_OVERRIDE_VAL_I = 8'h00;
  ppo_pins_t TOGGLE_OVERRIDE_EN_I = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  ppo_pins_t INPUT_EN_OVERRIDE_EN_I = 8'h00, INPUT_EN_OVERRIDE_VAL_I = 8'h00;
  ppo_pins_t PAD_I, PAD_O, PAD_OE_N_O, PULLUP_EN_O, OUT_REG_BIT_O, DIR_BIT_O;
  ppo_pins_t ALT_DIGITAL_IN_O, PIN_CHANGE_SRC_O;
  int err_total = 0, checked = 0;

  ppo_port dut_u (.*);
  ppo_pad_model pad_u (.clk_i(CLK_I), .pad_o_i(PAD_O), .oe_n_i(PAD_OE_N_O),
    .pullup_i(PULLUP_EN_O), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_i_o(PAD_I));

  initial begin
    forever #20 CLK_I = ~CLK_I;
  end

  task automatic chk(input string n, input ppo_pins_t exp, input ppo_pins_t got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask

  // request held until pready seen high
  task automatic apb(input logic w, input ppo_addr_t a, input ppo_data_t d);
    @(posedge CLK_I);
    PSEL_I <= 1;
    PENABLE_I <= 0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    // wait ends once PREADY_O is seen high, or by the watchdog
    do begin
      @(posedge CLK_I);
    end while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 0;
    PENABLE_I <= 0;
  endtask

  task automatic rd(input ppo_addr_t a, input ppo_data_t exp);
    apb(0, a, 32'h0000_0000);
    checked++;
    if (q !== exp) begin
      err_total++;
      $display("unexpected rdata %h expected %h seen %h", a, exp, q);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLK_I);
    err_total++;
    tally_and_finish;
  end

  initial begin
    wt(10);
    chk("pullup", 8'h00, PULLUP_EN_O);
    chk("oe_n", 8'hFF, PAD_OE_N_O);
    @(posedge CLK_I);
    RST_N_I <= 1;
    PULLUP_OVERRIDE_EN_I <= 8'h00;
    PULLUP_OVERRIDE_VAL_I <= 8'h00;
    apb(1, PPO_DIR_ADDR, 32'h0000_000F);
    apb(1, PPO_OUT_ADDR, 32'h0000_00A5);
    wt(1);
    chk("oe_n", 8'hF0, PAD_OE_N_O);
    chk("pad_o", 8'h05, PAD_O & ~PAD_OE_N_O);
    chk("pullup", 8'hA0, PULLUP_EN_O);
    apb(1, PPO_CTRL_ADDR, 32'h0000_0001);
    @(posedge CLK_I);
    PULLUP_OVERRIDE_EN_I <= 8'h30;
    PULLUP_OVERRIDE_VAL_I <= 8'h10;
    DIR_OVERRIDE_EN_I <= 8'h81;
    DIR_OVERRIDE_VAL_I <= 8'h80;
    OUT_VALUE_OVERRIDE_EN_I <= 8'h80;
    wt(1);
    chk("pullup", 8'h10, PULLUP_EN_O);
    chk("oe_n", 8'h71, PAD_OE_N_O);
    chk("pad_o", 8'h04, PAD_O & ~PAD_OE_N_O);
    chk("dir_bit", 8'h0F, DIR_BIT_O);
    chk("pud", 8'h01, {7'h00, GLOBAL_PULLUP_DISABLE_O});
    // second reset with every pull-up override asking for on
    @(posedge CLK_I);
    RST_N_I <= 0;
    PULLUP_OVERRIDE_EN_I <= 8'hFF;
    PULLUP_OVERRIDE_VAL_I <= 8'hFF;
    wt(2);
    chk("pullup", 8'h00, PULLUP_EN_O);
    chk("oe_n", 8'hFF, PAD_OE_N_O);
    @(posedge CLK_I);
    RST_N_I <= 1;
    PULLUP_OVERRIDE_EN_I <= 8'h00;
    PULLUP_OVERRIDE_VAL_I <= 8'h00;
    DIR_OVERRIDE_EN_I <= 8'h00;
    OUT_VALUE_OVERRIDE_EN_I <= 8'h00;
    apb(1, PPO_OUT_ADDR, 32'h0000_00A5);
    apb(1, PPO_PIN_ADDR, 32'h0000_000F);
    rd(PPO_OUT_ADDR, 32'h0000_00AA);
    @(posedge CLK_I);
    TOGGLE_OVERRIDE_EN_I <= 8'h01;
    @(posedge CLK_I);
    TOGGLE_OVERRIDE_EN_I <= 8'h00;
    wt(1);
    chk("out_bit", 8'hAB, OUT_REG_BIT_O);
    @(posedge CLK_I);
    ext_en <= 8'hFF;
    ext_val <= 8'h55;
    apb(1, PPO_RISE_ADDR, 32'h0000_0010);
    wt(3);
    chk("alt_in", 8'h55, ALT_DIGITAL_IN_O);
    chk("pin_change", 8'h55, PIN_CHANGE_SRC_O);
    chk("alt_map", 8'hD5, {MAIN_OSC_IN_O, TIMER_OSC_IN_O, SPI_SCK_IN_O, SPI_MISO_IN_O,
      SPI_MOSI_IN_O, SPI_SS_IN_O, 1'b0, TIMER1_CAPTURE_IN_O});
    @(posedge CLK_I);
    SLEEP_I <= 1;
    wt(1);
    chk("alt_in", 8'h00, ALT_DIGITAL_IN_O);
    apb(1, PPO_CTRL_ADDR, 32'h0000_0002);
    apb(1, PPO_IEN_ADDR, 32'h0000_0001);
    wt(1);
    chk("alt_in", 8'h01, ALT_DIGITAL_IN_O);
    @(posedge CLK_I);
    INPUT_EN_OVERRIDE_EN_I <= 8'h44;
    INPUT_EN_OVERRIDE_VAL_I <= 8'h04;
    wt(1);
    chk("alt_in", 8'h05, ALT_DIGITAL_IN_O);
    apb(1, PPO_CLR_ADDR, 32'h0000_00FF);
    @(posedge CLK_I);
    SLEEP_I <= 0;
    wt(6);
    chk("alt_in", 8'h15, ALT_DIGITAL_IN_O);
    rd(PPO_PIN_ADDR, 32'h0000_0015);
    rd(PPO_STAT_ADDR, 32'h0000_0010);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    apb(1, PPO_IEN_ADDR, 32'h0000_0011);
    wt(1);
    chk("irq", 8'h01, {7'h00, IRQ_O});
    // mask with the flag still set
    apb(1, PPO_IEN_ADDR, 32'h0000_0000);
    wt(1);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    apb(1, PPO_IEN_ADDR, 32'h0000_0011);
    apb(1, PPO_CLR_ADDR, 32'h0000_0010);
    wt(1);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    rd(PPO_CLR_ADDR, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk("slverr", 8'h01, {7'h00, e});
    apb(1, PPO_IEN_ADDR, 32'h0000_0000);
    wt(1);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    tally_and_finish;
  end
endmodule
